// file: rtl/haptic_pkg.sv
/*
 * Constants and types shared by the haptic playback control block.
 * Assumes an 8-bit register map reached over a two-wire serial bus.
 */
package haptic_pkg;
    // Register offsets
    localparam logic [7:0] REG_MODE      = 8'h01;
    localparam logic [7:0] REG_REALTIME  = 8'h02;
    localparam logic [7:0] REG_SLOT0     = 8'h04;
    localparam logic [7:0] REG_SLOT7     = 8'h0B;
    localparam logic [7:0] REG_GO        = 8'h0C;
    localparam logic [7:0] REG_CTRL_A    = 8'h1B;
    localparam logic [7:0] REG_CTRL_B    = 8'h1C;
    localparam logic [7:0] REG_CTRL_C    = 8'h1D;
    localparam logic [7:0] REG_RAM_HI    = 8'hFD;
    localparam logic [7:0] REG_RAM_LO    = 8'hFE;
    localparam logic [7:0] REG_RAM_DATA  = 8'hFF;

    // Field positions and reset values
    localparam int         STANDBY_BIT   = 6;
    localparam int         GO_BIT        = 0;
    localparam int         RESONANT_BIT  = 7;
    localparam int         UNIDIR_BIT    = 7;
    localparam int         OPEN_LOOP_BIT = 0;
    localparam int         ANALOG_BIT    = 1;
    localparam logic [7:0] MODE_RESET    = 8'h40;

    // Mode field values
    localparam logic [2:0] MODE_INT      = 3'h0;
    localparam logic [2:0] MODE_EDGE     = 3'h1;
    localparam logic [2:0] MODE_LEVEL    = 3'h2;
    localparam logic [2:0] MODE_PWM      = 3'h3;
    localparam logic [2:0] MODE_REALTIME = 3'h5;

    // Sequencer and RAM layout
    localparam logic [2:0] LAST_SLOT     = 3'h7;
    localparam int         STRIDE_SHIFT  = 4;

    // Timing
    localparam int         PWRUP_WAIT_US = 250;
    localparam int         SYS_CLK_MHZ   = 10;
    localparam int         PWRUP_CYCLES  = PWRUP_WAIT_US * SYS_CLK_MHZ;
    localparam int         PU_W          = 12;
    localparam int         TICK_W        = 16;

    typedef enum logic [3:0] {
        I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_REG, I2C_ACK_REG,
        I2C_WDATA, I2C_ACK_W, I2C_RDATA, I2C_RACK
    } i2c_st_t;

    typedef enum logic [1:0] {
        P_IDLE, P_FETCH, P_PLAY
    } play_st_t;
endpackage : haptic_pkg

// file: rtl/haptic_playback_control.sv
/*
 * Register bank, serial slave, playback sequencer and actuator drive stage.
 * Assumes an open-drain serial bus resolved outside, an enable pin, a trigger
 * pin, a back-EMF zero-cross comparator and a separate drive clock.
 */
`timescale 1ns/1ps
`default_nettype none
module haptic_playback_control
    import haptic_pkg::*;
#(
    parameter logic [6:0]        DEV_ADDR      = 7'h2C, // Arbitrary value
    parameter int                RAM_AW        = 12,
    parameter logic [TICK_W-1:0] SAMPLE_CYCLES = 16'h1388,
    parameter logic [15:0]       OPEN_HALF     = 16'h2B67
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic       drive_clk_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_n_o,
    input  wire logic       enable_pin_i,
    input  wire logic       input_trigger_pin_i,
    input  wire logic [7:0] analog_level_i,
    input  wire logic       backemf_zc_i,
    output var  logic       drive_pwm_o,
    output var  logic       drive_dir_o,
    output var  logic       standby_o,
    output var  logic       playing_o
);
    typedef struct packed {
        logic [1:0]        scl_sy, sda_sy, en_sy, trig_sy;
        logic [7:0]        ana_s1, ana_s2;
        logic              scl_q, sda_q, trig_q;
        logic [PU_W-1:0]   pu_cnt;
        logic              pu_done;
        i2c_st_t           ist;
        logic [3:0]        bitcnt;
        logic [7:0]        shreg;
        logic              rw, ackd, sda_low;
        logic [7:0]        ptr;
        logic [7:0]        mode_reg, realtime_reg, ctrl_a, ctrl_b, ctrl_c, ram_hi, ram_lo;
        logic [7:0][7:0]   slots;
        logic              go;
        play_st_t          pst;
        logic [2:0]        seq;
        logic [15:0]       paddr;
        logic [TICK_W-1:0] tick;
        logic [7:0]        play_amp;
        logic [10:0]       src, sent;
        logic              req;
        logic [1:0]        ack_sy;
        logic              standby_q, playing_q;
    } sys_t;

    typedef struct packed {
        logic [2:0]  req_sy, zc_sy;
        logic        ack;
        logic [7:0]  amp;
        logic        reso, openl, unidir;
        logic [7:0]  pwm_cnt;
        logic [15:0] half_cnt;
        logic        dir, out;
    } drv_t;

    sys_t        s_ff, nxt_s;
    drv_t        d_ff, nxt_d;
    logic [7:0]  wave_ram [2**RAM_AW];
    logic        ram_we;
    logic        go_wr;
    logic        scl_rise, scl_fall, start_c, stop_c, trig_rise, lowpower, zc_edge;
    logic [2:0]  mode;
    logic [15:0] ram_ptr;
    logic [7:0]  play_byte;

    assign scl_rise  = s_ff.scl_sy[1] & ~s_ff.scl_q;
    assign scl_fall  = ~s_ff.scl_sy[1] & s_ff.scl_q;
    assign start_c   = s_ff.scl_sy[1] & s_ff.scl_q & s_ff.sda_q & ~s_ff.sda_sy[1];
    assign stop_c    = s_ff.scl_sy[1] & s_ff.scl_q & ~s_ff.sda_q & s_ff.sda_sy[1];
    assign trig_rise = s_ff.trig_sy[1] & ~s_ff.trig_q;
    assign mode      = s_ff.mode_reg[2:0];
    assign lowpower  = s_ff.mode_reg[STANDBY_BIT] | ~s_ff.en_sy[1];
    assign ram_ptr   = {s_ff.ram_hi, s_ff.ram_lo};
    assign play_byte = wave_ram[s_ff.paddr[RAM_AW-1:0]];
    assign zc_edge   = d_ff.zc_sy[1] ^ d_ff.zc_sy[2];

    function automatic logic [7:0] read_reg(input logic [7:0] p);
        if (p == REG_MODE) return s_ff.mode_reg;
        else if (p == REG_REALTIME) return s_ff.realtime_reg;
        else if (p >= REG_SLOT0 && p <= REG_SLOT7) return s_ff.slots[3'(p - REG_SLOT0)];
        else if (p == REG_GO) return {7'h00, s_ff.go};
        else if (p == REG_CTRL_A) return s_ff.ctrl_a;
        else if (p == REG_CTRL_B) return s_ff.ctrl_b;
        else if (p == REG_CTRL_C) return s_ff.ctrl_c;
        else if (p == REG_RAM_HI) return s_ff.ram_hi;
        else if (p == REG_RAM_LO) return s_ff.ram_lo;
        else if (p == REG_RAM_DATA) return wave_ram[ram_ptr[RAM_AW-1:0]];
        else return 8'h00;
    endfunction : read_reg

    // Pointer stays on the RAM data port so bursts stream into RAM
    function automatic logic [7:0] adv(input logic [7:0] p);
        return (p == REG_RAM_DATA) ? p : p + 8'h01;
    endfunction : adv

    always_comb
    begin
        logic [7:0] rd;
        logic [7:0] idx;
        logic [7:0] amp;
        go_wr  = 1'b0;
        rd     = 8'h00;
        idx    = 8'h00;
        amp    = 8'h00;
        nxt_s  = s_ff;
        ram_we = 1'b0;
        if (clk_en_i)
        begin
            nxt_s.scl_sy  = {s_ff.scl_sy[0], scl_i};
            nxt_s.sda_sy  = {s_ff.sda_sy[0], sda_i};
            nxt_s.en_sy   = {s_ff.en_sy[0], enable_pin_i};
            nxt_s.trig_sy = {s_ff.trig_sy[0], input_trigger_pin_i};
            nxt_s.ana_s1  = analog_level_i;
            nxt_s.ana_s2  = s_ff.ana_s1;
            nxt_s.scl_q   = s_ff.scl_sy[1];
            nxt_s.sda_q   = s_ff.sda_sy[1];
            nxt_s.trig_q  = s_ff.trig_sy[1];
            if (!s_ff.pu_done)
            begin
                nxt_s.pu_cnt = s_ff.pu_cnt + PU_W'(1);
                if (s_ff.pu_cnt == PU_W'(PWRUP_CYCLES - 1))
                    nxt_s.pu_done = 1'b1;
            end
            // Serial slave
            if (start_c)
            begin
                nxt_s.ist     = I2C_ADDR;
                nxt_s.bitcnt  = 4'h0;
                nxt_s.sda_low = 1'b0;
            end
            else if (stop_c)
            begin
                nxt_s.ist     = I2C_IDLE;
                nxt_s.sda_low = 1'b0;
            end
            else if (scl_rise)
            begin
                case (s_ff.ist)
                    I2C_ADDR, I2C_REG, I2C_WDATA:
                    begin
                        nxt_s.shreg  = {s_ff.shreg[6:0], s_ff.sda_sy[1]};
                        nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                    end
                    I2C_RDATA: nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                    I2C_RACK:  nxt_s.ackd = ~s_ff.sda_sy[1];
                    default:   ;
                endcase
            end
            else if (scl_fall)
            begin
                case (s_ff.ist)
                    I2C_ADDR:
                        if (s_ff.bitcnt == 4'h8)
                        begin
                            if (s_ff.shreg[7:1] == DEV_ADDR && s_ff.pu_done)
                            begin
                                nxt_s.rw      = s_ff.shreg[0];
                                nxt_s.sda_low = 1'b1;
                                nxt_s.ist     = I2C_ACK_ADDR;
                            end
                            else
                                nxt_s.ist = I2C_IDLE;
                        end
                    I2C_REG:
                        if (s_ff.bitcnt == 4'h8)
                        begin
                            nxt_s.ptr     = s_ff.shreg;
                            nxt_s.sda_low = 1'b1;
                            nxt_s.ist     = I2C_ACK_REG;
                        end
                    I2C_WDATA:
                        if (s_ff.bitcnt == 4'h8)
                        begin
                            nxt_s.sda_low = 1'b1;
                            nxt_s.ist     = I2C_ACK_W;
                            nxt_s.ptr     = adv(s_ff.ptr);
                            if (s_ff.ptr == REG_MODE)
                                nxt_s.mode_reg = s_ff.shreg;
                            else if (s_ff.ptr == REG_REALTIME)
                                nxt_s.realtime_reg = s_ff.shreg;
                            else if (s_ff.ptr >= REG_SLOT0 && s_ff.ptr <= REG_SLOT7)
                                nxt_s.slots[3'(s_ff.ptr - REG_SLOT0)] = s_ff.shreg;
                            else if (s_ff.ptr == REG_GO)
                                go_wr = 1'b1;
                            else if (s_ff.ptr == REG_CTRL_A)
                                nxt_s.ctrl_a = s_ff.shreg;
                            else if (s_ff.ptr == REG_CTRL_B)
                                nxt_s.ctrl_b = s_ff.shreg;
                            else if (s_ff.ptr == REG_CTRL_C)
                                nxt_s.ctrl_c = s_ff.shreg;
                            else if (s_ff.ptr == REG_RAM_HI)
                                nxt_s.ram_hi = s_ff.shreg;
                            else if (s_ff.ptr == REG_RAM_LO)
                                nxt_s.ram_lo = s_ff.shreg;
                            else if (s_ff.ptr == REG_RAM_DATA)
                            begin
                                ram_we = 1'b1;
                                {nxt_s.ram_hi, nxt_s.ram_lo} = ram_ptr + 16'h0001;
                            end
                        end
                    I2C_ACK_ADDR:
                        if (s_ff.rw)
                        begin
                            rd            = read_reg(s_ff.ptr);
                            nxt_s.shreg   = {rd[6:0], 1'b0};
                            nxt_s.sda_low = ~rd[7];
                            nxt_s.bitcnt  = 4'h0;
                            nxt_s.ist     = I2C_RDATA;
                        end
                        else
                        begin
                            nxt_s.sda_low = 1'b0;
                            nxt_s.bitcnt  = 4'h0;
                            nxt_s.ist     = I2C_REG;
                        end
                    I2C_ACK_REG, I2C_ACK_W:
                    begin
                        nxt_s.sda_low = 1'b0;
                        nxt_s.bitcnt  = 4'h0;
                        nxt_s.ist     = I2C_WDATA;
                    end
                    I2C_RDATA:
                        if (s_ff.bitcnt == 4'h8)
                        begin
                            nxt_s.sda_low = 1'b0;
                            nxt_s.ist     = I2C_RACK;
                        end
                        else
                        begin
                            nxt_s.sda_low = ~s_ff.shreg[7];
                            nxt_s.shreg   = {s_ff.shreg[6:0], 1'b0};
                        end
                    I2C_RACK:
                        if (s_ff.ackd)
                        begin
                            nxt_s.ptr     = adv(s_ff.ptr);
                            rd            = read_reg(adv(s_ff.ptr));
                            nxt_s.shreg   = {rd[6:0], 1'b0};
                            nxt_s.sda_low = ~rd[7];
                            nxt_s.bitcnt  = 4'h0;
                            nxt_s.ist     = I2C_RDATA;
                        end
                        else
                            nxt_s.ist = I2C_IDLE;
                    default: ;
                endcase
            end
            // Sequencer; slots are only read, so a new trigger replays them
            if (!s_ff.go || lowpower || mode > MODE_LEVEL)
            begin
                nxt_s.pst      = P_IDLE;
                nxt_s.play_amp = 8'h00;
            end
            else
            begin
                case (s_ff.pst)
                    P_IDLE:
                    begin
                        nxt_s.pst = P_FETCH;
                        nxt_s.seq = 3'h0;
                    end
                    P_FETCH:
                    begin
                        idx = s_ff.slots[s_ff.seq];
                        if (idx == 8'h00)
                        begin
                            nxt_s.pst = P_IDLE;
                            nxt_s.go  = 1'b0;
                        end
                        else
                        begin
                            nxt_s.paddr = 16'(idx) << STRIDE_SHIFT;
                            nxt_s.tick  = '0;
                            nxt_s.pst   = P_PLAY;
                        end
                    end
                    P_PLAY:
                        if (s_ff.tick == SAMPLE_CYCLES - TICK_W'(1))
                        begin
                            nxt_s.tick = '0;
                            if (play_byte != 8'h00)
                            begin
                                nxt_s.play_amp = play_byte;
                                nxt_s.paddr    = s_ff.paddr + 16'h0001;
                            end
                            else if (s_ff.seq == LAST_SLOT)
                            begin
                                nxt_s.pst      = P_IDLE;
                                nxt_s.go       = 1'b0;
                                nxt_s.play_amp = 8'h00;
                            end
                            else
                            begin
                                nxt_s.seq      = s_ff.seq + 3'h1;
                                nxt_s.pst      = P_FETCH;
                                nxt_s.play_amp = 8'h00;
                            end
                        end
                        else
                            nxt_s.tick = s_ff.tick + TICK_W'(1);
                    default: nxt_s.pst = P_IDLE;
                endcase
            end
            // Trigger sources; a set overrides the completion clear
            if (lowpower)
                nxt_s.go = 1'b0;
            else if (mode == MODE_EDGE && trig_rise)
                nxt_s.go = 1'b1;
            else if (mode == MODE_LEVEL)
                nxt_s.go = s_ff.trig_sy[1];
            else if (go_wr)
                nxt_s.go = s_ff.shreg[GO_BIT];
            nxt_s.playing_q = (nxt_s.pst != P_IDLE);
            nxt_s.standby_q = lowpower;
            // Amplitude source
            if (lowpower)
                amp = 8'h00;
            else if (mode == MODE_REALTIME)
                amp = s_ff.realtime_reg;
            else if (mode == MODE_PWM)
                amp = s_ff.ctrl_c[ANALOG_BIT] ? s_ff.ana_s2 : {8{s_ff.trig_sy[1]}};
            else
                amp = s_ff.play_amp;
            nxt_s.src    = {s_ff.ctrl_a[RESONANT_BIT], s_ff.ctrl_c[OPEN_LOOP_BIT],
                            s_ff.ctrl_b[UNIDIR_BIT], amp};
            nxt_s.ack_sy = {s_ff.ack_sy[0], d_ff.ack};
            if (s_ff.req == s_ff.ack_sy[1] && s_ff.src != s_ff.sent)
            begin
                nxt_s.sent = s_ff.src;
                nxt_s.req  = ~s_ff.req;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_ff          <= '0;
            s_ff.mode_reg <= MODE_RESET;
        end
        else
            s_ff <= nxt_s;
    end

    always_ff @(posedge clock_i)
    begin
        if (ram_we)
            wave_ram[ram_ptr[RAM_AW-1:0]] <= s_ff.shreg;
    end

    // Drive stage on the drive clock
    always_comb
    begin
        nxt_d         = d_ff;
        nxt_d.req_sy  = {d_ff.req_sy[1:0], s_ff.req};
        nxt_d.zc_sy   = {d_ff.zc_sy[1:0], backemf_zc_i};
        nxt_d.pwm_cnt = d_ff.pwm_cnt + 8'h01;
        nxt_d.out     = d_ff.pwm_cnt < d_ff.amp;
        if (d_ff.req_sy[1] != d_ff.req_sy[2])
        begin
            {nxt_d.reso, nxt_d.openl, nxt_d.unidir, nxt_d.amp} = s_ff.sent;
            nxt_d.ack = d_ff.req_sy[1];
        end
        nxt_d.half_cnt = d_ff.half_cnt + 16'h0001;
        if (d_ff.reso && !d_ff.openl)
        begin
            if (zc_edge)
            begin
                nxt_d.dir      = ~d_ff.dir;
                nxt_d.half_cnt = 16'h0000;
            end
        end
        else if (d_ff.reso)
        begin
            if (d_ff.half_cnt >= OPEN_HALF - 16'h0001)
            begin
                nxt_d.dir      = ~d_ff.dir;
                nxt_d.half_cnt = 16'h0000;
            end
        end
        else
            nxt_d.dir = 1'b0;
    end

    always_ff @(posedge drive_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            d_ff <= '0;
        else
            d_ff <= nxt_d;
    end

    assign sda_o       = 1'b0;
    assign sda_oe_n_o  = ~s_ff.sda_low;
    assign drive_pwm_o = d_ff.out;
    assign drive_dir_o = d_ff.dir;
    assign standby_o   = s_ff.standby_q;
    assign playing_o   = s_ff.playing_q;

    chk_early_no_ack: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !s_ff.pu_done |-> sda_oe_n_o)
        else $error("bus acknowledged before power-up wait");
    chk_lowpower_go: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && lowpower |=> !s_ff.go && !playing_o)
        else $error("trigger state kept in low power");
    chk_standby_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && scl_fall && s_ff.ist == I2C_WDATA && s_ff.bitcnt == 4'h8
        && s_ff.ptr == REG_MODE && s_ff.shreg[STANDBY_BIT] ##1 clk_en_i
        |=> standby_o && mode == $past(s_ff.shreg[2:0], 2))
        else $error("standby and mode not taken in one write");
    chk_ram_autoinc: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ram_we |=> ram_ptr == $past(ram_ptr) + 16'h0001)
        else $error("RAM address did not advance");
    chk_ptr_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ram_we |=> s_ff.ptr == REG_RAM_DATA)
        else $error("pointer left RAM data port");
    chk_edge_fire: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && !lowpower && mode == MODE_EDGE && trig_rise |=> s_ff.go)
        else $error("edge trigger did not fire");
    chk_fire_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && s_ff.go && !lowpower && mode == MODE_INT && s_ff.pst == P_FETCH
        && s_ff.slots[s_ff.seq] == 8'h00 && !go_wr |=> !s_ff.go ##1 !playing_o)
        else $error("fire bit not cleared at end");
    chk_realtime_amp: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && !lowpower && mode == MODE_REALTIME
        |=> s_ff.src[7:0] == $past(s_ff.realtime_reg))
        else $error("real-time amplitude not selected");
    chk_reso_flip: assert property (@(posedge drive_clk_i) disable iff (!rst_n_i)
        d_ff.reso && !d_ff.openl && zc_edge |=> drive_dir_o != $past(drive_dir_o)
        && d_ff.half_cnt == 16'h0000)
        else $error("drive did not follow zero cross");
endmodule : haptic_playback_control
`default_nettype wire

// file: tb/bus_host.sv
/* Two-wire bus host model. Assumes SDA is resolved with a pull-up outside. */
`timescale 1ns/1ps
`default_nettype none
module bus_host #(parameter logic [6:0] ADDR = 7'h2C) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic pins(input logic s, input logic c);
        sda_o = s;
        scl_o = c;
        repeat (4) @(negedge clk_i);
    endtask : pins
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, inout logic ok);
        for (int i = 7; i >= -1; i--)
        begin
            pins(i < 0 ? 1'b1 : tx[i], 1'b0);
            pins(i < 0 ? 1'b1 : tx[i], 1'b1);
            if (i >= 0) rx[i] = sda_i;
            else ok = ok & ~sda_i;
            pins(i < 0 ? 1'b1 : tx[i], 1'b0);
        end
    endtask : xfer
    task automatic start_cond;
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
    endtask : start_cond
    task automatic stop_cond;
        pins(1'b0, 1'b0);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
    endtask : stop_cond
    task automatic wr(input logic [7:0] r, input logic [7:0] v, output logic ok);
        logic [7:0] x;
        ok = 1'b1;
        start_cond();
        xfer({ADDR, 1'b0}, x, ok);
        xfer(r, x, ok);
        xfer(v, x, ok);
        stop_cond();
    endtask : wr
    task automatic rd(input logic [7:0] r, output logic [7:0] v);
        logic ok;
        ok = 1'b1;
        start_cond();
        xfer({ADDR, 1'b0}, v, ok);
        xfer(r, v, ok);
        start_cond();
        xfer({ADDR, 1'b1}, v, ok);
        xfer(8'hFF, v, ok);
        stop_cond();
    endtask : rd
endmodule : bus_host
`default_nettype wire

// file: tb/test_haptic_playback_control.sv
/* Bench for the playback block. Assumes the bus host model and an SDA pull-up. */
`timescale 1ns/1ps
`default_nettype none
module test_haptic_playback_control;
    import haptic_pkg::*;
    logic       clock_i = 1'b0, drive_clk = 1'b0, rst_n_i = 1'b0;
    logic       enable = 1'b1, trig = 1'b0, zc = 1'b0;
    logic       scl, host_sda, dev_sda, oe_n, pwm, dir, stby, play, ok;
    logic [7:0] d;
    logic [7:0] ram_bytes[3] = '{8'h55, 8'h66, 8'h00};
    logic [2:0] modes[3] = '{MODE_PWM, MODE_REALTIME, MODE_LEVEL};
    logic [7:0] ana = 8'h30;
    int         errors = 0;
    int         check_count = 0;
    wire logic  sda = host_sda & (oe_n | dev_sda);
    initial forever #50 clock_i = ~clock_i;
    initial forever #7.5 drive_clk = ~drive_clk;
    always #3000 zc = ~zc;
    haptic_playback_control #(.SAMPLE_CYCLES(16'd40), .OPEN_HALF(16'd8)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .drive_clk_i(drive_clk),
        .scl_i(scl), .sda_i(sda), .sda_o(dev_sda), .sda_oe_n_o(oe_n),
        .enable_pin_i(enable), .input_trigger_pin_i(trig), .analog_level_i(ana),
        .backemf_zc_i(zc), .drive_pwm_o(pwm), .drive_dir_o(dir), .standby_o(stby),
        .playing_o(play));
    bus_host host (.clk_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wt(input logic v);
        for (int i = 0; i < 400 && play !== v; i++) @(negedge clock_i);
        chk(play, v);
    endtask : wt
    // High drive cycles over one full 256-step PWM period
    task automatic duty(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        repeat (256)
        begin
            @(negedge drive_clk);
            n = n + 8'(pwm);
        end
        chk(n, e);
    endtask : duty
    task automatic end_sim;
        $display("errors=%0d check_count=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial
    begin
        #5000000;
        errors++;
        end_sim();
    end
    initial
    begin
        // Trigger pin grounded, calibration store taken as programmed
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        chk(oe_n, 1'b1);
        chk(stby, 1'b1);
        host.wr(REG_MODE, 8'h00, ok);
        chk(ok, 1'b0);
        repeat (2600) @(negedge clock_i);
        host.wr(REG_MODE, 8'h00, ok);
        chk(ok, 1'b1);
        chk(stby, 1'b0);
        for (int r = 0; r < 3; r++)
        begin
            host.rd(REG_CTRL_A + 8'(r), d);
            chk(d, 8'h00);
        end
        host.wr(REG_RAM_HI, 8'h00, ok);
        host.wr(REG_RAM_LO, 8'h10, ok);
        foreach (ram_bytes[i]) host.wr(REG_RAM_DATA, ram_bytes[i], ok);
        host.wr(REG_RAM_LO, 8'h11, ok);
        host.rd(REG_RAM_DATA, d);
        chk(d, 8'h66);
        host.wr(REG_SLOT0, 8'h01, ok);
        repeat (2)
        begin
            host.wr(REG_GO, 8'h01, ok);
            wt(1'b1);
            wt(1'b0);
            host.rd(REG_GO, d);
            chk(d, 8'h00);
        end
        host.wr(REG_MODE, {5'h00, MODE_EDGE}, ok);
        trig = 1'b1;
        repeat (6) @(negedge clock_i);
        trig = 1'b0;
        wt(1'b1);
        wt(1'b0);
        enable = 1'b0;
        repeat (5) @(negedge clock_i);
        chk(stby, 1'b1);
        enable = 1'b1;
        foreach (modes[i])
        begin
            host.wr(REG_MODE, {5'h00, modes[i]}, ok);
            host.rd(REG_MODE, d);
            chk(d, {5'h00, modes[i]});
        end
        trig = 1'b1;
        wt(1'b1);
        trig = 1'b0;
        wt(1'b0);
        host.wr(REG_MODE, {5'h00, MODE_REALTIME}, ok);
        host.wr(REG_REALTIME, 8'h7F, ok);
        host.rd(REG_REALTIME, d);
        chk(d, 8'h7F);
        duty(8'h7F);
        host.wr(REG_MODE, {5'h00, MODE_PWM}, ok);
        host.wr(REG_CTRL_C, 8'h02, ok);
        host.rd(REG_CTRL_C, d);
        chk(d, 8'h02);
        duty(8'h30);
        chk({7'h00, dir}, 8'h00);
        host.wr(REG_CTRL_A, 8'h80, ok);
        @(zc);
        repeat (2) @(negedge clock_i);
        d[0] = dir;
        @(zc);
        repeat (2) @(negedge clock_i);
        chk({7'h00, dir}, {7'h00, ~d[0]});
        host.rd(8'h30, d);
        chk(d, 8'h00);
        host.wr(REG_MODE, MODE_RESET, ok);
        chk(stby, 1'b1);
        host.wr(REG_GO, 8'h01, ok);
        repeat (5) @(negedge clock_i);
        chk(play, 1'b0);
        host.rd(REG_GO, d);
        chk(d, 8'h00);
        duty(8'h00);
        end_sim();
    end
endmodule : test_haptic_playback_control
`default_nettype wire
